// *** core/usdp_data_port.sv ***
// Purpose: shadow receive/transmit data port of a uart, AHB-Lite slave
// Assumes: characters arrive from and leave to an external serializer
// Notes: zero wait state slave; reads pop in the address phase
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "usdp_params.svh"
module usdp_data_port #(
  parameter int RX_DEPTH = `USDP_RX_DEPTH,
  parameter int TX_DEPTH = `USDP_TX_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // ******************************
  // ahb-lite slave
  // ******************************
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // ******************************
  // receive side
  // ******************************
  input  wire logic        uart_rx_valid,
  input  wire logic [7:0]  uart_rx_data,
  input  wire logic        ir_rx_valid,
  input  wire logic [7:0]  ir_rx_data,
  // ******************************
  // transmit side
  // ******************************
  output logic             uart_tx_valid,
  input  wire logic        uart_tx_ready,
  output logic             ir_tx_valid,
  input  wire logic        ir_tx_ready,
  output logic      [7:0]  tx_data,
  // ******************************
  // flags towards line state logic
  // ******************************
  output logic             receive_data_ready_flag,
  output logic             tx_holding_empty_flag,
  output logic             overrun_flag,
  output logic             fifo_enable,
  output logic             ir_mode
);
  import usdp_pkg::*;

  usdp_state_t st_r;
  usdp_state_t st_nxt;

  // ******************************
  // address phase decode
  // ******************************
  logic      addr_ok;
  logic      in_shadow;
  usdp_acc_t acc;
  logic      rd_now;
  logic      wr_now;

  assign addr_ok   = hsel && hready && htrans[1];
  assign in_shadow = (haddr >= `USDP_SHADOW_FIRST)
                  && (haddr <= `USDP_SHADOW_LAST)
                  && (haddr[1:0] == 2'b00);

  always_comb begin
    if (in_shadow) begin
      acc = USDP_ACC_DATA;
    end else if (haddr == `USDP_CTRL_ADDR) begin
      acc = USDP_ACC_CTRL;
    end else if (haddr == `USDP_STAT_ADDR) begin
      acc = USDP_ACC_STAT;
    end else begin
      acc = USDP_ACC_NONE;
    end
  end

  assign rd_now = addr_ok && !hwrite;
  assign wr_now = addr_ok && hwrite;

  // ******************************
  // receive path
  // ******************************
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       rx_push;
  logic       rx_pop;
  logic [7:0] rx_head;
  logic       rx_empty;
  logic       rx_full;
  logic       rx_rdy_flag;
  logic       flush;

  // source follows the line mode
  assign rx_valid = st_r.ir_mode ? ir_rx_valid : uart_rx_valid;
  assign rx_byte  = st_r.ir_mode ? ir_rx_data : uart_rx_data;

  assign rx_rdy_flag = st_r.fifo_en ? !rx_empty : st_r.rx_rdy;
  assign rx_pop      = rd_now && (acc == USDP_ACC_DATA) && rx_rdy_flag;
  // full fifo keeps its entries unless a read frees a slot this cycle
  assign rx_push = st_r.fifo_en && rx_valid && (!rx_full || rx_pop);

  usdp_fifo #(
    .W (8),
    .D (RX_DEPTH)
  ) u_rx_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .flush (flush),
    .push  (rx_push),
    .pop   (rx_pop && st_r.fifo_en),
    .wdata (rx_byte),
    .rdata (rx_head),
    .empty (rx_empty),
    .full  (rx_full)
  );

  // ******************************
  // transmit path
  // ******************************
  logic       wr_data;
  logic [7:0] wr_byte;
  logic       tx_push;
  logic       tx_pop;
  logic [7:0] tx_head;
  logic       tx_empty;
  logic       tx_full;
  logic       src_valid;
  logic       src_ready;
  logic [7:0] src_data;
  logic       buf_valid;
  logic       buf_ready;

  // writes land in the data phase, one cycle after the address phase
  assign wr_data = (st_r.wr_acc == USDP_ACC_DATA);
  assign wr_byte = hwdata[7:0];

  assign tx_push = wr_data && st_r.fifo_en && !tx_full;
  assign tx_pop  = st_r.fifo_en && !tx_empty && src_ready;

  usdp_fifo #(
    .W (8),
    .D (TX_DEPTH)
  ) u_tx_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .flush (flush),
    .push  (tx_push),
    .pop   (tx_pop),
    .wdata (wr_byte),
    .rdata (tx_head),
    .empty (tx_empty),
    .full  (tx_full)
  );

  assign src_valid = st_r.fifo_en ? !tx_empty : st_r.tx_hold_full;
  assign src_data  = st_r.fifo_en ? tx_head : st_r.tx_hold;

  // stall by the serializer fills this buffer, then holds the source
  usdp_buf2 #(
    .W (8)
  ) u_tx_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (tx_data)
  );

  assign uart_tx_valid = buf_valid && !st_r.ir_mode;
  assign ir_tx_valid   = buf_valid && st_r.ir_mode;
  assign buf_ready     = st_r.ir_mode ? ir_tx_ready : uart_tx_ready;

  // ******************************
  // control write and fifo flush
  // ******************************
  logic wr_ctrl;
  logic new_fifo_en;

  assign wr_ctrl     = (st_r.wr_acc == USDP_ACC_CTRL);
  assign new_fifo_en = hwdata[`USDP_CTRL_FIFO_EN];
  // toggling the fifo mode empties both fifos; bytes already in the transmit buffer u_tx_buf still go out
  assign flush       = wr_ctrl && (new_fifo_en != st_r.fifo_en);

  // ******************************
  // next state
  // ******************************
  logic rd_stat;
  logic rx_lost;

  assign rd_stat = rd_now && (acc == USDP_ACC_STAT);
  assign rx_lost = st_r.fifo_en ? (rx_valid && rx_full && !rx_pop)
                                : (rx_valid && st_r.rx_rdy && !rx_pop);

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_acc = wr_now ? acc : USDP_ACC_NONE;

    // single holding byte when fifos are off
    if (!st_r.fifo_en) begin
      if (rx_valid) begin
        st_nxt.rx_hold = rx_byte;
        st_nxt.rx_rdy  = 1'b1;
      end else if (rx_pop) begin
        st_nxt.rx_rdy = 1'b0;
      end
    end

    if (!st_r.fifo_en) begin
      if (src_valid && src_ready) begin
        st_nxt.tx_hold_full = 1'b0;
      end
      if (wr_data) begin
        st_nxt.tx_hold      = wr_byte;
        st_nxt.tx_hold_full = 1'b1;
      end
    end

    // status read clears overrun; a new loss in that cycle wins
    if (rd_stat) begin
      st_nxt.overrun = 1'b0;
    end
    if (rx_lost) begin
      st_nxt.overrun = 1'b1;
    end

    if (wr_ctrl) begin
      st_nxt.fifo_en = new_fifo_en;
      st_nxt.ir_mode = hwdata[`USDP_CTRL_IR_MODE];
      if (flush) begin
        st_nxt.rx_rdy       = 1'b0;
        st_nxt.tx_hold_full = 1'b0;
      end
    end

    // read data is captured at the address phase edge
    st_nxt.rdata = '0;
    if (rd_now) begin
      unique case (acc)
        USDP_ACC_DATA: begin
          // upper byte of the 16-bit register and above read zero
          st_nxt.rdata[15:0] = `USDP_DATA_RESET;
          st_nxt.rdata[7:0]  = st_r.fifo_en ? rx_head : st_r.rx_hold;
        end
        USDP_ACC_CTRL: begin
          st_nxt.rdata[`USDP_CTRL_FIFO_EN] = st_r.fifo_en;
          st_nxt.rdata[`USDP_CTRL_IR_MODE] = st_r.ir_mode;
        end
        USDP_ACC_STAT: begin
          st_nxt.rdata[`USDP_STAT_RX_READY] = rx_rdy_flag;
          st_nxt.rdata[`USDP_STAT_OVERRUN] = st_r.overrun;
          st_nxt.rdata[`USDP_STAT_TX_FULL] = st_r.fifo_en && tx_full;
          st_nxt.rdata[`USDP_STAT_RX_FULL] = st_r.fifo_en && rx_full;
          st_nxt.rdata[`USDP_STAT_TX_EMPTY] = tx_holding_empty_flag;
        end
        USDP_ACC_NONE: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.rdata;

  assign receive_data_ready_flag = rx_rdy_flag;
  // empty flag follows the fifo in fifo mode, the holding byte otherwise
  assign tx_holding_empty_flag   = st_r.fifo_en ? tx_empty : !st_r.tx_hold_full;
  assign overrun_flag            = st_r.overrun;
  assign fifo_enable             = st_r.fifo_en;
  assign ir_mode                 = st_r.ir_mode;

  // hsize is accepted but only whole-word accesses are meaningful
  logic unused_ok;
  assign unused_ok = ^{hsize, htrans[0]};
endmodule : usdp_data_port

// *** common/usdp_params.svh ***
// Purpose: addresses, field positions and reset values of the shadow data port
// Assumes: word-aligned AHB-Lite accesses
// Notes: included by bare name
`ifndef USDP_PARAMS_SVH
`define USDP_PARAMS_SVH
`define USDP_SHADOW4_ADDR 32'h5000_1140
`define USDP_SHADOW_FIRST 32'h5000_1130
`define USDP_SHADOW_LAST  32'h5000_116c
`define USDP_CTRL_ADDR    32'h5000_1180
`define USDP_STAT_ADDR    32'h5000_1184
`define USDP_DATA_RESET   16'h0000
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_STAT_RX_READY 0
`define USDP_STAT_OVERRUN 1
`define USDP_STAT_TX_FULL 2
`define USDP_STAT_RX_FULL 3
`define USDP_STAT_TX_EMPTY 5
`define USDP_RX_DEPTH     16
`define USDP_TX_DEPTH     16
`endif

// *** common/usdp_pkg.sv ***
// Purpose: types of the shadow data port
// Assumes: nothing
// Notes: constants live in usdp_params.svh
package usdp_pkg;

  typedef enum logic [1:0] {
    USDP_ACC_NONE = 2'b00,
    USDP_ACC_DATA = 2'b01,
    USDP_ACC_CTRL = 2'b10,
    USDP_ACC_STAT = 2'b11
  } usdp_acc_t;

  typedef struct packed {
    usdp_acc_t   wr_acc;
    logic [7:0]  rx_hold;
    logic        rx_rdy;
    logic [7:0]  tx_hold;
    logic        tx_hold_full;
    logic        overrun;
    logic        fifo_en;
    logic        ir_mode;
    logic [31:0] rdata;
  } usdp_state_t;

endpackage : usdp_pkg

// *** core/usdp_fifo.sv ***
// Purpose: synchronous fifo with flush
// Assumes: D is a power of two, at least 2
// Notes: push while full is accepted only together with a pop
`timescale 1ns/10ps
module usdp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] rdata,
  output logic              empty,
  output logic              full
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } usdp_fifo_st_t;
  usdp_fifo_st_t st_r;
  usdp_fifo_st_t st_nxt;
  logic do_push;
  logic do_pop;

  assign empty = (st_r.cnt == '0);
  assign full  = (st_r.cnt == (AW+1)'(D));
  assign rdata = st_r.mem[st_r.rp];
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);

  always_comb begin
    st_nxt = st_r;
    if (do_push) begin
      st_nxt.mem[st_r.wp] = wdata;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (do_pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush) begin
      st_nxt.wp  = '0;
      st_nxt.rp  = '0;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : usdp_fifo

// *** core/usdp_buf2.sv ***
// Purpose: two-entry buffer between transmit holding and serializer
// Assumes: nothing
// Notes: a stall downstream fills it, then in_ready drops
`timescale 1ns/10ps
module usdp_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } usdp_buf_st_t;
  usdp_buf_st_t st_r;
  usdp_buf_st_t st_nxt;
  logic take;
  logic give;

  assign in_ready  = (st_r.cnt != 2'd2);
  assign out_valid = (st_r.cnt != 2'd0);
  assign out_data  = st_r.mem[st_r.rp];
  assign take = in_valid && in_ready;
  assign give = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (take) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = ~st_r.wp;
    end
    if (give) begin
      st_nxt.rp = ~st_r.rp;
    end
    st_nxt.cnt = st_r.cnt + 2'(take) - 2'(give);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : usdp_buf2

// *** bench/usdp_chk.sv ***
// Purpose: pin-level checks on the shadow data port
// Assumes: one clock domain, reset low active
// Notes: bound from the bench top file
`timescale 1ns/10ps
`include "usdp_params.svh"
module usdp_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        uart_rx_valid,
  input wire logic        ir_rx_valid,
  input wire logic        uart_tx_valid,
  input wire logic        uart_tx_ready,
  input wire logic        ir_tx_valid,
  input wire logic        ir_tx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic        receive_data_ready_flag,
  input wire logic        tx_holding_empty_flag,
  input wire logic        overrun_flag,
  input wire logic        fifo_enable,
  input wire logic        ir_mode
);
  // ****
  // access decode
  // ****
  logic take;
  logic shadow;
  assign take   = hsel && hready && htrans[1];
  assign shadow = haddr >= `USDP_SHADOW_FIRST && haddr <= `USDP_SHADOW_LAST;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence shadow_wr;
    take && hwrite && shadow ##1 !fifo_enable && tx_holding_empty_flag;
  endsequence
  sequence shadow_rd;
    take && !hwrite && shadow;
  endsequence
  a_holding_clears: assert property (shadow_wr |=> !tx_holding_empty_flag)
    else $error("holding empty stayed set");
  a_read_pops: assert property (shadow_rd ##0 (receive_data_ready_flag && !fifo_enable
    && !uart_rx_valid && !ir_rx_valid) |=> !receive_data_ready_flag)
    else $error("data ready kept after read");
  a_uart_rx_ready: assert property (uart_rx_valid && !ir_mode
    |=> receive_data_ready_flag || $changed(fifo_enable))
    else $error("uart byte not flagged");
  a_ir_rx_ready: assert property (ir_rx_valid && ir_mode
    |=> receive_data_ready_flag || $changed(fifo_enable))
    else $error("infrared byte not flagged");
  a_overrun_off: assert property (!fifo_enable && receive_data_ready_flag
    && (ir_mode ? ir_rx_valid : uart_rx_valid)
    && !(take && !hwrite && shadow) |=> overrun_flag)
    else $error("overrun not flagged");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rdata_idle: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_uart_tx_hold: assert property (uart_tx_valid && !uart_tx_ready
    |=> uart_tx_valid && $stable(tx_data))
    else $error("uart byte dropped before taken");
  a_ir_tx_hold: assert property (ir_tx_valid && !ir_tx_ready
    |=> ir_tx_valid && $stable(tx_data))
    else $error("infrared byte dropped before taken");
  a_one_line: assert property (!(uart_tx_valid && ir_tx_valid))
    else $error("both transmit lines offered");
endmodule : usdp_chk

// *** bench/usdp_line_model.sv ***
// Purpose: far-side uart and infrared transceiver
// Assumes: received bytes come as one-cycle pulses
// Notes: bench sets stall and reads got
`timescale 1ns/10ps
module usdp_line_model (
  input  wire logic       clk,
  output logic            uart_rx_valid,
  output logic      [7:0] uart_rx_data,
  output logic            ir_rx_valid,
  output logic      [7:0] ir_rx_data,
  input  wire logic       uart_tx_valid,
  output logic            uart_tx_ready,
  input  wire logic       ir_tx_valid,
  output logic            ir_tx_ready,
  input  wire logic [7:0] tx_data
);
  logic       stall = 1'b0;
  logic [8:0] got[$];
  initial begin
    uart_rx_valid = 1'b0;
    ir_rx_valid   = 1'b0;
    uart_rx_data  = 8'h0;
    ir_rx_data    = 8'h0;
  end
  assign uart_tx_ready = !stall;
  assign ir_tx_ready   = !stall;
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge clk);
    uart_rx_valid <= !ir;
    ir_rx_valid   <= ir;
    uart_rx_data  <= b;
    ir_rx_data    <= b;
    @(posedge clk);
    uart_rx_valid <= 1'b0;
    ir_rx_valid   <= 1'b0;
    // stale data would let a late sample pass
    uart_rx_data  <= ~b;
    ir_rx_data    <= ~b;
  endtask : send
  always @(posedge clk) begin
    if ((uart_tx_valid && uart_tx_ready) || (ir_tx_valid && ir_tx_ready)) begin
      got.push_back({ir_tx_valid, tx_data});
    end
  end
endmodule : usdp_line_model

// *** bench/tb_uart_shadow_data_port.sv ***
// Purpose: self-checking bench of the shadow data port
// Assumes: zero wait state slave, small fifo depths
// Notes: checker bound at the foot
`timescale 1ns/10ps
`include "usdp_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_uart_shadow_data_port;
  localparam int          RXD  = 4;
  localparam int          TXD  = 4;
  localparam logic [31:0] S_RDY = 32'h1 << `USDP_STAT_RX_READY;
  localparam logic [31:0] S_OV = 32'h1 << `USDP_STAT_OVERRUN;
  localparam logic [31:0] S_TF = 32'h1 << `USDP_STAT_TX_FULL;
  localparam logic [31:0] S_RF = 32'h1 << `USDP_STAT_RX_FULL;
  localparam logic [31:0] S_TE = 32'h1 << `USDP_STAT_TX_EMPTY;
  logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, uart_rx_valid, ir_rx_valid, uart_tx_valid, uart_tx_ready;
  logic        ir_tx_valid, ir_tx_ready, receive_data_ready_flag, tx_holding_empty_flag;
  logic        overrun_flag, fifo_enable, ir_mode;
  logic [7:0]  uart_rx_data, ir_rx_data, tx_data;
  logic [8:0]  v;
  int          err_count = 0, cmp_count = 0;
  usdp_data_port #(.RX_DEPTH(RXD), .TX_DEPTH(TXD)) dut (.clk, .rst_b, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .uart_rx_valid,
    .uart_rx_data, .ir_rx_valid, .ir_rx_data, .uart_tx_valid, .uart_tx_ready, .ir_tx_valid,
    .ir_tx_ready, .tx_data, .receive_data_ready_flag, .tx_holding_empty_flag, .overrun_flag,
    .fifo_enable, .ir_mode);
  usdp_line_model lm (.clk, .uart_rx_valid, .uart_rx_data, .ir_rx_valid, .ir_rx_data,
    .uart_tx_valid, .uart_tx_ready, .ir_tx_valid, .ir_tx_ready, .tx_data);
  always #2 clk = ~clk;
  // ****
  // bus access and closing
  // ****
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // ****
  // scenarios
  // ****
  task automatic t_idle();
    ahb(1'b0, `USDP_STAT_ADDR, 32'h0, rd);
    `CHK(rd, S_TE)
    `CHK(hresp, 1'b0)
    ahb(1'b0, `USDP_SHADOW4_ADDR, 32'h0, rd); `CHK(rd, 32'h0)
    ahb(1'b1, 32'h5000_1190, 32'hff, rd);
    ahb(1'b0, 32'h5000_1190, 32'h0, rd); `CHK(rd, 32'h0)
    $display("idle test done");
  endtask : t_idle
  task automatic t_rx();
    lm.send(1'b0, 8'ha5);
    ahb(1'b0, `USDP_STAT_ADDR, 32'h0, rd);
    `CHK(rd, S_RDY | S_TE)
    ahb(1'b0, `USDP_SHADOW_FIRST, 32'h0, rd);
    `CHK(rd, 32'ha5)
    ahb(1'b1, `USDP_CTRL_ADDR, 32'h2, rd);
    ahb(1'b0, `USDP_CTRL_ADDR, 32'h0, rd);
    `CHK(rd, 32'h2)
    `CHK(ir_mode, 1'b1)
    lm.send(1'b1, 8'h3c);
    ahb(1'b0, `USDP_SHADOW_LAST, 32'h0, rd); `CHK(rd, 32'h3c)
    lm.send(1'b1, 8'h01);
    lm.send(1'b1, 8'h02);
    ahb(1'b0, `USDP_STAT_ADDR, 32'h0, rd);
    `CHK(rd, S_RDY | S_OV | S_TE)
    ahb(1'b0, `USDP_SHADOW4_ADDR, 32'h0, rd); `CHK(rd, 32'h02)
    $display("receive test done");
  endtask : t_rx
  task automatic t_rx_fifo();
    ahb(1'b1, `USDP_CTRL_ADDR, 32'h1, rd);
    for (int i = 0; i <= RXD; i++) lm.send(1'b0, 8'h60 + 8'(i));
    ahb(1'b0, `USDP_STAT_ADDR, 32'h0, rd);
    `CHK(rd, S_RDY | S_OV | S_RF | S_TE)
    for (int i = 0; i < RXD; i++) begin
      ahb(1'b0, `USDP_SHADOW4_ADDR, 32'h0, rd); `CHK(rd, 32'h60 + 32'(i))
    end
    ahb(1'b0, `USDP_STAT_ADDR, 32'h0, rd); `CHK(rd, S_TE)
    $display("receive fifo test done");
  endtask : t_rx_fifo
  task automatic t_tx(input logic ir, input int n, input int keep);
    ahb(1'b1, `USDP_CTRL_ADDR, {30'h0, ir, ir}, rd);
    lm.stall <= 1'b1;
    `CHK(tx_holding_empty_flag, 1'b1)
    for (int i = 0; i < n; i++) begin
      ahb(1'b1, `USDP_SHADOW_FIRST + 32'(4 * i), 32'hffff_ff80 + 32'(i), rd);
    end
    ahb(1'b0, `USDP_STAT_ADDR, 32'h0, rd); `CHK(rd & (S_TF | S_TE), ir ? S_TF : 32'h0)
    if (!ir) ahb(1'b1, `USDP_SHADOW4_ADDR, 32'h8a, rd);
    lm.stall <= 1'b0;
    for (int c = 0; c < 100; c++) begin
      if (tx_holding_empty_flag === 1'b1 && uart_tx_valid === 1'b0
          && ir_tx_valid === 1'b0) begin
        break;
      end
      @(posedge clk);
    end
    `CHK(lm.got.size(), keep)
    for (int i = 0; i < keep; i++) begin
      v = lm.got.pop_front();
      `CHK(v, {ir, (!ir && i == keep - 1) ? 8'h8a : 8'h80 + 8'(i)})
    end
    lm.got.delete();
    $display("transmit test done");
  endtask : t_tx
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_idle();
    t_rx();
    t_rx_fifo();
    t_tx(1'b0, 3, 3);
    t_tx(1'b1, TXD + 3, TXD + 2);
    results();
  end
  initial begin
    #40000;
    err_count++;
    results();
  end
endmodule : tb_uart_shadow_data_port
bind usdp_data_port usdp_chk u_chk (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .uart_rx_valid, .ir_rx_valid, .uart_tx_valid, .uart_tx_ready, .ir_tx_valid,
  .ir_tx_ready, .tx_data, .receive_data_ready_flag, .tx_holding_empty_flag, .overrun_flag,
  .fifo_enable, .ir_mode);
